// file: design/diag_adc_seq.sv
// Diagnostic converter sequencer: modes, slot walk, buffer timing, offset correction
// How it works
// - Reset selects automatic mode; bit 0 set means direct.
// - Early trigger waits for buffer warm-up timer.
// - Power-down while busy: delay, stop, then off.
// - Nothing converts until trigger bit set.
// - Result reads never disturb conversions.
// - Direct: one pass start to stop, idle.
// - Direct: trigger self-clears at sequence end.
// - Auto: repeat; trigger 0 stops after slot.
// - Busy flag high while converting, low idle.
// - Sixteen slots bounded by start, stop indices.
// - Fixed slot order, offset, inputs, diagnostics, ground.
// - Equal indices convert one slot, else step.
// - Start resets to 0, stop to 8.
// - Unconfigured second input reads zero, full time.
// - Start above stop acts as stop equals start.
// - Oscillator over 16; at least 20 periods.
// - Fixed 2560 Hz except external inputs.
// - Low supply refuses external wide-range bit.
// - Output slot range follows supply level.
// - Offset register holds 7FFh minus offset result.
// - Correction subtracted unless bypass set; offset slot always stored raw.
module diag_adc_seq
    import diag_adc_pkg::*;
#(
    parameter int WARMUP_CYCLES_P = WARMUP_CYCLES,
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic io_supply_high,
    input wire logic [11:0] sar_result,
    output logic buffer_enable,
    output logic converter_enable,
    output logic sar_start,
    output logic [3:0] sar_channel,
    output logic sar_range_wide
);
    conv_if cv ();

    seq_state_type state;
    logic [3:0] slot;
    logic supply_meta;
    logic supply_high;
    logic cfg_direct;
    logic cfg_pd;
    logic cfg_wide;
    logic [1:0] cfg_rate;
    logic cfg_extb_en;
    logic [3:0] idx_start;
    logic [3:0] idx_stop;
    logic trigger;
    logic ofs_bypass;
    logic [11:0] offset_corr;
    logic [11:0] result [16];
    logic buf_ready;
    logic stop_req;
    logic [19:0] hold_cnt;
    logic wr_cfg;
    logic wr_trig;
    logic pd_change;
    logic timer_run;
    logic timer_hit;
    logic pd_expire;
    logic [3:0] stop_eff;
    logic last;
    logic halt;
    logic seq_end;
    logic wrap;
    logic step;
    logic launch;
    logic launch_q;
    logic trig_clear;
    logic busy;

    // Conversion periods for a slot; only external inputs are programmable
    function automatic logic [7:0] slot_ticks(input logic [3:0] s, input logic [1:0] rate);
        logic [7:0] t;
        t = 8'(CONV_CLK_HZ / FIXED_RATE_HZ);
        if (s == SLOT_EXT_A || s == SLOT_EXT_B) begin
            unique case (rate)
                2'h0: t = 8'(CONV_CLK_HZ / RATE0_HZ);
                2'h1: t = 8'(CONV_CLK_HZ / RATE1_HZ);
                2'h2: t = 8'(CONV_CLK_HZ / RATE2_HZ);
                2'h3: t = 8'(CONV_CLK_HZ / RATE3_HZ);
            endcase
        end
        if (t < 8'(MIN_CONV_TICKS)) begin
            t = 8'(MIN_CONV_TICKS);
        end
        return t;
    endfunction

    // Subtract stored correction, saturating to the code range
    function automatic logic [11:0] correct(input logic [11:0] raw, input logic [11:0] ofs);
        logic signed [13:0] d;
        d = $signed({2'b00, raw}) - $signed({{2{ofs[11]}}, ofs});
        if (d < 0) begin
            return 12'h000;
        end
        if (d > 14'sh0FFF) begin
            return 12'hFFF;
        end
        return d[11:0];
    endfunction

    conv_timer #(
        .TICK_CYCLES_P(TICK_CYCLES_P)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .cv(cv)
    );

    // Supply level pin is asynchronous to clk
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            supply_meta <= 1'b0;
            supply_high <= 1'b0;
        end else begin
            supply_meta <= io_supply_high;
            supply_high <= supply_meta;
        end
    end

    assign wr_cfg = reg_wr && (reg_addr == REG_CFG);
    assign wr_trig = reg_wr && (reg_addr == REG_TRIGGER);
    assign pd_change = wr_cfg && (reg_wdata[CFG_PD_BIT] != cfg_pd);
    assign busy = (state != ST_IDLE);

    // Sequence bounds and slot-end decisions
    assign stop_eff = (idx_start > idx_stop) ? idx_start : idx_stop;
    assign last = (slot == stop_eff);
    assign halt = stop_req || (!cfg_direct && !trigger);
    assign seq_end = cv.done && (halt || (last && cfg_direct));
    assign wrap = cv.done && last && !cfg_direct && !halt;
    assign step = cv.done && !last && !halt;
    assign launch = ((state == ST_WAIT) && trigger && !cfg_pd && buf_ready) || wrap || step;
    assign trig_clear = (cv.done && last && cfg_direct) || pd_expire;

    // Configuration register; wide range cannot stick at low supply
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_direct <= 1'b0;
            cfg_pd <= 1'b1;
            cfg_wide <= 1'b0;
            cfg_rate <= RATE_RESET;
            cfg_extb_en <= 1'b0;
        end else if (wr_cfg) begin
            cfg_direct <= reg_wdata[CFG_DIRECT_BIT];
            cfg_pd <= reg_wdata[CFG_PD_BIT];
            cfg_wide <= reg_wdata[CFG_WIDE_BIT] && supply_high;
            cfg_rate <= reg_wdata[CFG_RATE_LSB +: 2];
            cfg_extb_en <= reg_wdata[CFG_EXTB_BIT];
        end else if (!supply_high) begin
            cfg_wide <= 1'b0;
        end
    end

    // Index and bypass registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_start <= START_RESET;
            idx_stop <= STOP_RESET;
            ofs_bypass <= 1'b0;
        end else if (reg_wr && reg_addr == REG_INDEX) begin
            idx_start <= reg_wdata[INDEX_START_LSB +: 4];
            idx_stop <= reg_wdata[INDEX_STOP_LSB +: 4];
        end else if (reg_wr && reg_addr == REG_BYPASS) begin
            ofs_bypass <= reg_wdata[0];
        end
    end

    // Trigger bit: a software write in the same cycle beats the self-clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trigger <= 1'b0;
        end else if (wr_trig) begin
            trigger <= reg_wdata[0];
        end else if (trig_clear) begin
            trigger <= 1'b0;
        end
    end

    // One timer serves warm-up and the delayed power-down
    assign timer_run = cfg_pd ? (busy && !stop_req) : !buf_ready;
    assign timer_hit = (hold_cnt == 20'(WARMUP_CYCLES_P - 1));
    assign pd_expire = cfg_pd && timer_run && timer_hit;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt <= 20'h00000;
        end else if (pd_change || (timer_run && timer_hit)) begin
            hold_cnt <= 20'h00000;
        end else if (timer_run) begin
            hold_cnt <= hold_cnt + 20'h00001;
        end
    end

    // Buffer power and readiness; power stays on until the walk has stopped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            buffer_enable <= 1'b0;
            buf_ready <= 1'b0;
            stop_req <= 1'b0;
        end else if (cfg_pd) begin
            if (!busy) begin
                buffer_enable <= 1'b0;
                buf_ready <= 1'b0;
                stop_req <= 1'b0;
            end else if (pd_expire) begin
                stop_req <= 1'b1;
            end
        end else begin
            buffer_enable <= 1'b1;
            stop_req <= 1'b0;
            if (timer_run && timer_hit) begin
                buf_ready <= 1'b1;
            end
        end
    end

    // Sequencer state and slot pointer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            slot <= START_RESET;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (trigger) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!trigger || cfg_pd) begin
                        state <= ST_IDLE;
                    end else if (buf_ready) begin
                        state <= ST_CONVERT;
                        slot <= idx_start;
                    end
                end
                ST_CONVERT: begin
                    if (seq_end) begin
                        state <= ST_IDLE;
                    end else if (wrap) begin
                        slot <= idx_start;
                    end else if (step) begin
                        slot <= slot + 4'h1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Slot launch goes out one cycle after the pointer settles, so the range flop is valid with it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            launch_q <= 1'b0;
            cv.start <= 1'b0;
        end else begin
            launch_q <= launch;
            cv.start <= launch_q;
        end
    end
    assign cv.ticks = slot_ticks(slot, cfg_rate);
    assign sar_start = cv.start;
    assign sar_channel = slot;

    // Range selection and converter enable toward the analog side
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sar_range_wide <= 1'b0;
            converter_enable <= 1'b0;
        end else begin
            converter_enable <= (state == ST_CONVERT) && !stop_req && !pd_expire;
            if (slot == SLOT_DIAG_OUT) begin
                sar_range_wide <= supply_high;
            end else if (slot == SLOT_EXT_A || slot == SLOT_EXT_B) begin
                sar_range_wide <= cfg_wide && supply_high;
            end else begin
                sar_range_wide <= 1'b0;
            end
        end
    end

    // Result store at slot end; offset slot also refreshes the correction
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            offset_corr <= 12'h000;
            for (int i = 0; i < 16; i++) begin
                result[i] <= 12'h000;
            end
        end else if (cv.done) begin
            if (slot == SLOT_OFFSET) begin
                result[slot] <= sar_result;
                offset_corr <= MID_SCALE - sar_result;
            end else if (slot == SLOT_EXT_B && !cfg_extb_en) begin
                result[slot] <= 12'h000;
            end else if (ofs_bypass) begin
                result[slot] <= sar_result;
            end else begin
                result[slot] <= correct(sar_result, offset_corr);
            end
        end
    end

    // Read port: side-effect free, data valid the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h00000000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_addr[7:6] == REG_RESULT_PAGE && reg_addr[1:0] == 2'h0) begin
            reg_rdata <= {20'h00000, result[reg_addr[5:2]]};
        end else begin
            unique case (reg_addr)
                REG_CFG: reg_rdata <= {26'h0000000, cfg_extb_en, cfg_rate, cfg_wide, cfg_pd, cfg_direct};
                REG_INDEX: reg_rdata <= {20'h00000, idx_stop, 4'h0, idx_start};
                REG_TRIGGER: reg_rdata <= {31'h00000000, trigger};
                REG_STATUS: reg_rdata <= {29'h00000000, supply_high, buf_ready, busy};
                REG_BYPASS: reg_rdata <= {31'h00000000, ofs_bypass};
                REG_OFFSET: reg_rdata <= {20'h00000, offset_corr};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_last_done;
        (state == ST_CONVERT) && cv.done && last;
    endsequence
    sequence s_auto_go;
        !cfg_direct && trigger && !stop_req && !wr_trig;
    endsequence

    property p_idle_holds;
        (state == ST_IDLE) && !trigger |=> (state != ST_CONVERT);
    endproperty
    a_idle_holds: assert property (p_idle_holds) else $error("conversion without trigger");
    property p_ready_first;
        (state == ST_CONVERT) |-> buf_ready;
    endproperty
    a_ready_first: assert property (p_ready_first) else $error("converting before warm-up");
    property p_self_clear;
        s_last_done ##0 (cfg_direct && !wr_trig) |=> !trigger && (state == ST_IDLE);
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("direct pass did not end");
    property p_auto_wrap;
        s_last_done ##0 s_auto_go |=> (slot == $past(idx_start)) ##1 sar_start;
    endproperty
    a_auto_wrap: assert property (p_auto_wrap) else $error("auto sequence did not restart");
    property p_busy_read;
        reg_rd && (reg_addr == REG_STATUS) |=> (reg_rdata[0] == $past(busy));
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy flag misreported");
    property p_extb_zero;
        cv.done && (slot == SLOT_EXT_B) && !cfg_extb_en |=> (result[SLOT_EXT_B] == 12'h000);
    endproperty
    a_extb_zero: assert property (p_extb_zero) else $error("unconfigured input not zero");
    property p_offset_calc;
        cv.done && (slot == SLOT_OFFSET) |=> (offset_corr == MID_SCALE - $past(sar_result));
    endproperty
    a_offset_calc: assert property (p_offset_calc) else $error("offset correction wrong");
    property p_wide_refused;
        !supply_high |=> !cfg_wide;
    endproperty
    a_wide_refused: assert property (p_wide_refused) else $error("wide range at low supply");
    property p_out_range;
        (slot == SLOT_DIAG_OUT) && $stable(slot) && $stable(supply_high) |=> (sar_range_wide == $past(supply_high));
    endproperty
    a_out_range: assert property (p_out_range) else $error("output slot range wrong");
    property p_bounds;
        (state == ST_CONVERT) && !(reg_wr && reg_addr == REG_INDEX) |-> (slot >= idx_start) && (slot <= stop_eff);
    endproperty
    a_bounds: assert property (p_bounds) else $error("slot outside index range");
endmodule

// file: design/diag_adc_pkg.sv
// Shared constants and types for the diagnostic converter sequencer
package diag_adc_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int OSC_HZ = 1_228_800;
    localparam int OSC_DIV = 16;
    localparam int CONV_CLK_HZ = OSC_HZ / OSC_DIV;
    localparam int TICK_CYCLES = CLK_HZ / CONV_CLK_HZ;
    localparam int MIN_CONV_TICKS = 20;
    localparam int FIXED_RATE_HZ = 2560;
    localparam int RATE0_HZ = 640;
    localparam int RATE1_HZ = 1280;
    localparam int RATE2_HZ = 2560;
    localparam int RATE3_HZ = 3840;
    localparam int WARMUP_US = 210;
    localparam int WARMUP_CYCLES = WARMUP_US * (CLK_HZ / 1_000_000);
    // Register byte addresses
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_INDEX = 8'h04;
    localparam logic [7:0] REG_TRIGGER = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_BYPASS = 8'h10;
    localparam logic [7:0] REG_OFFSET = 8'h28;
    localparam logic [1:0] REG_RESULT_PAGE = 2'h1;
    // Field positions
    localparam int CFG_DIRECT_BIT = 0;
    localparam int CFG_PD_BIT = 1;
    localparam int CFG_WIDE_BIT = 2;
    localparam int CFG_RATE_LSB = 3;
    localparam int CFG_EXTB_BIT = 5;
    localparam int INDEX_START_LSB = 0;
    localparam int INDEX_STOP_LSB = 8;
    // Reset values
    localparam logic [3:0] START_RESET = 4'h0;
    localparam logic [3:0] STOP_RESET = 4'h8;
    localparam logic [1:0] RATE_RESET = 2'h2;
    // Fixed slot order
    localparam logic [3:0] SLOT_OFFSET = 4'h0;
    localparam logic [3:0] SLOT_EXT_A = 4'h1;
    localparam logic [3:0] SLOT_EXT_B = 4'h2;
    localparam logic [3:0] SLOT_DIAG_OUT = 4'h8;
    localparam logic [11:0] MID_SCALE = 12'h7FF;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_CONVERT = 2'b10
    } seq_state_type;
endpackage

// file: design/conv_if.sv
// Handshake between sequencer and conversion timer
interface conv_if;
    logic start;
    logic [7:0] ticks;
    logic done;
    modport ctl (output start, output ticks, input done);
    modport tmr (input start, input ticks, output done);
endinterface

// file: design/conv_timer.sv
// Converter clock enable divider and per-slot conversion time counter
module conv_timer
    import diag_adc_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    conv_if.tmr cv
);
    logic [11:0] div;
    logic [7:0] left;
    logic running;
    logic tick;

    // One-cycle enable at the converter clock rate
    assign tick = running && (div == 12'(TICK_CYCLES_P - 1));
    assign cv.done = tick && (left == 8'h01);

    // Divider restarts with each slot so every slot gets whole periods
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div <= 12'h000;
        end else if (cv.start || tick) begin
            div <= 12'h000;
        end else if (running) begin
            div <= div + 12'h001;
        end
    end

    // Remaining converter clock periods of the current slot
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            left <= 8'h00;
            running <= 1'b0;
        end else if (cv.start) begin
            left <= cv.ticks;
            running <= 1'b1;
        end else if (tick) begin
            left <= left - 8'h01;
            running <= (left != 8'h01);
        end
    end
endmodule

// file: sim/testbench.sv
// Self-checking bench for the diagnostic converter sequencer
module testbench
    import diag_adc_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    // Short warm-up and converter period keep the run small; slot tick counts are unchanged
    localparam int WARM = 20;
    localparam int TICK = 4;
    localparam int SLOT_MIN = MIN_CONV_TICKS * TICK;

    logic clk;
    logic rst_b;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic io_supply_high;
    logic [11:0] sar_result;
    logic buffer_enable;
    logic converter_enable;
    logic sar_start;
    logic [3:0] sar_channel;
    logic sar_range_wide;
    int num_errors = 0;
    int samples_checked = 0;
    int starts = 0;
    int cyc = 0;
    int start_cyc = 0;
    logic [3:0] last_chan;
    logic last_wide;

    diag_adc_seq #(.WARMUP_CYCLES_P(WARM), .TICK_CYCLES_P(TICK)) diag_adc_seq_i (
        .clk(clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .io_supply_high(io_supply_high),
        .sar_result(sar_result),
        .buffer_enable(buffer_enable),
        .converter_enable(converter_enable),
        .sar_start(sar_start),
        .sar_channel(sar_channel),
        .sar_range_wide(sar_range_wide)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Cycle count and capture of every slot start with its selection
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sar_start === 1'b1) begin
            starts <= starts + 1;
            start_cyc <= cyc;
            last_chan <= sar_channel;
            last_wide <= sar_range_wide;
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic expect_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        reg_read(a, d);
        check(name, d, exp);
    endtask

    // Waits, bounded, until the slot start count reaches n
    task automatic wait_starts(input int n);
        for (int k = 0; k < 2000 && starts < n; k++) @(posedge clk);
    endtask

    // Polls the busy flag until it reads low, bounded so a hang still ends the run
    task automatic wait_idle(output logic idle);
        logic [31:0] d;
        idle = 1'b0;
        for (int k = 0; k < 500 && !idle; k++) begin
            reg_read(REG_STATUS, d);
            idle = (d[0] === 1'b0);
        end
    endtask

    task automatic t_reset_values();
        check("buffer_enable", {31'h0, buffer_enable}, 32'h0);
        check("converter_enable", {31'h0, converter_enable}, 32'h0);
        expect_reg("cfg", REG_CFG, 32'h0000_0012);
        expect_reg("index", REG_INDEX, 32'h0000_0800);
        expect_reg("trigger", REG_TRIGGER, 32'h0);
        expect_reg("status", REG_STATUS, 32'h0000_0004);
        expect_reg("bypass", REG_BYPASS, 32'h0);
        expect_reg("unmapped", 8'h3C, 32'h0);
        $display("test reset_values done");
    endtask

    task automatic t_wide_refused();
        io_supply_high <= 1'b0;
        repeat (4) @(posedge clk);
        reg_write(REG_CFG, 32'h0000_001F);
        expect_reg("cfg_low_supply", REG_CFG, 32'h0000_001B);
        expect_reg("status_low_supply", REG_STATUS, 32'h0);
        io_supply_high <= 1'b1;
        repeat (4) @(posedge clk);
        reg_write(REG_CFG, 32'h0000_001F);
        expect_reg("cfg_high_supply", REG_CFG, 32'h0000_001F);
        $display("test wide_refused done");
    endtask

    task automatic t_idle_no_trigger();
        repeat (200) @(posedge clk);
        check("starts_untriggered", starts, 32'h0);
        expect_reg("status_idle", REG_STATUS, 32'h0000_0004);
        $display("test idle_no_trigger done");
    endtask

    // Start above stop must give one pass over the start slot only
    task automatic t_direct_pass();
        int t0;
        int i;
        int elapsed;
        logic done;
        logic [31:0] d;
        reg_write(REG_INDEX, 32'h0000_0102);
        reg_write(REG_CFG, 32'h0000_001D);
        t0 = cyc;
        // Early trigger, long before warm-up ends
        reg_write(REG_TRIGGER, 32'h0000_0001);
        for (i = 0; i < 2000 && starts == 0; i++) @(posedge clk);
        check("first_start_count", starts, 32'h1);
        check("warmup_held", {31'h0, (start_cyc - t0) >= WARM}, 32'h1);
        check("slot_selected", {28'h0, last_chan}, {28'h0, SLOT_EXT_B});
        check("ext_range_wide", {31'h0, last_wide}, 32'h1);
        expect_reg("status_busy", REG_STATUS, 32'h0000_0007);
        expect_reg("result_during", 8'h48, 32'h0);
        done = 1'b0;
        for (i = 0; i < 300 && !done; i++) begin
            repeat (10) @(posedge clk);
            reg_read(REG_TRIGGER, d);
            if (d[0] === 1'b0) done = 1'b1;
        end
        elapsed = cyc - start_cyc;
        check("trigger_self_clear", {31'h0, done}, 32'h1);
        check("slot_min_time", {31'h0, elapsed >= SLOT_MIN}, 32'h1);
        check("single_slot_count", starts, 32'h1);
        expect_reg("status_done", REG_STATUS, 32'h0000_0006);
        expect_reg("ext_b_unconfigured", 8'h48, 32'h0);
        repeat (500) @(posedge clk);
        check("stays_idle", starts, 32'h1);
        check("converter_off", {31'h0, converter_enable}, 32'h0);
        $display("test direct_pass done");
    endtask

    // Auto walk over offset and both inputs, restart, then stop by clearing the trigger
    task automatic t_auto_offset();
        int n0;
        logic idle;
        sar_result <= 12'h7F0;
        reg_write(REG_INDEX, 32'h0000_0200);
        reg_write(REG_CFG, 32'h0000_0030);
        n0 = starts;
        reg_write(REG_TRIGGER, 32'h0000_0001);
        wait_starts(n0 + 4);
        check("auto_restart_slot", {28'h0, last_chan}, {28'h0, SLOT_OFFSET});
        check("auto_fixed_range", {31'h0, last_wide}, 32'h0);
        expect_reg("offset_reg", REG_OFFSET, {20'h0, MID_SCALE - 12'h7F0});
        expect_reg("offset_slot_raw", 8'h40, 32'h0000_07F0);
        expect_reg("ext_a_corrected", 8'h44, {20'h0, 12'h7F0 - (MID_SCALE - 12'h7F0)});
        expect_reg("ext_b_configured", 8'h48, {20'h0, 12'h7F0 - (MID_SCALE - 12'h7F0)});
        reg_write(REG_TRIGGER, 32'h0);
        wait_idle(idle);
        check("auto_stopped", {31'h0, idle}, 32'h1);
        check("auto_stop_count", starts, n0 + 4);
        $display("test auto_offset done");
    endtask

    // Output slot alone in direct mode with the correction bypassed
    task automatic t_out_slot_bypass();
        int n0;
        logic idle;
        reg_write(REG_BYPASS, 32'h0000_0001);
        reg_write(REG_INDEX, 32'h0000_0808);
        reg_write(REG_CFG, 32'h0000_0031);
        n0 = starts;
        reg_write(REG_TRIGGER, 32'h0000_0001);
        wait_idle(idle);
        check("out_slot_idle", {31'h0, idle}, 32'h1);
        check("out_slot_count", starts, n0 + 1);
        check("out_slot_chan", {28'h0, last_chan}, {28'h0, SLOT_DIAG_OUT});
        check("out_range_high_supply", {31'h0, last_wide}, 32'h1);
        expect_reg("out_bypassed", 8'h60, 32'h0000_07F0);
        $display("test out_slot_bypass done");
    endtask

    // Power-down inside an auto slot: delayed stop, slot finishes, then buffer off
    task automatic t_powerdown_busy();
        int n0;
        logic idle;
        reg_write(REG_INDEX, 32'h0000_0101);
        reg_write(REG_CFG, 32'h0000_0030);
        n0 = starts;
        reg_write(REG_TRIGGER, 32'h0000_0001);
        wait_starts(n0 + 1);
        reg_write(REG_CFG, 32'h0000_0032);
        #1;
        check("conv_held_on", {31'h0, converter_enable}, 32'h1);
        repeat (WARM + 4) @(posedge clk);
        #1;
        check("conv_disabled", {31'h0, converter_enable}, 32'h0);
        check("buffer_kept", {31'h0, buffer_enable}, 32'h1);
        expect_reg("pd_trigger_clear", REG_TRIGGER, 32'h0);
        expect_reg("pd_still_busy", REG_STATUS, 32'h0000_0007);
        wait_idle(idle);
        check("pd_idle", {31'h0, idle}, 32'h1);
        check("buffer_off_after", {31'h0, buffer_enable}, 32'h0);
        check("pd_no_restart", starts, n0 + 1);
        $display("test powerdown_busy done");
    endtask

    task automatic t_powerdown_idle();
        reg_write(REG_CFG, 32'h0000_001F);
        repeat (WARM + 20) @(posedge clk);
        check("buffer_off", {31'h0, buffer_enable}, 32'h0);
        expect_reg("status_pd", REG_STATUS, 32'h0000_0004);
        $display("test powerdown_idle done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        io_supply_high = 1'b1;
        sar_result = 12'h123;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset_values();
        t_wide_refused();
        t_idle_no_trigger();
        t_direct_pass();
        t_auto_offset();
        t_out_slot_bypass();
        t_powerdown_busy();
        t_powerdown_idle();
        complete_run();
    end

    // Watchdog well above the few thousand cycles that the shortened slots need
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("mismatch watchdog expected finish seen timeout");
        complete_run();
    end
endmodule
